/* rtl/cll_pkg.sv */
// Constants for the comparator logic table bank.
// Assumes a single system clock and no software register bus.
package cll_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int unsigned NUM_LUT  = 4;   // Table instances
	localparam int unsigned NUM_CMP  = 4;   // Comparator outputs
	localparam int unsigned FUNC_W   = 4;   // Function word width
	localparam int unsigned SEL_W    = 2;   // Comparator select width

	// ----------------------------------------------------------------
	// Reset values and function codes
	// ----------------------------------------------------------------
	localparam logic [3:0] FUNC_RST   = 4'h0;
	localparam logic [3:0] FUNC_ZERO  = 4'h0;
	localparam logic [3:0] FUNC_AND   = 4'h1;
	localparam logic [3:0] FUNC_ANB   = 4'h2;
	localparam logic [3:0] FUNC_A     = 4'h3;
	localparam logic [3:0] FUNC_NAB   = 4'h4;
	localparam logic [3:0] FUNC_B     = 4'h5;
	localparam logic [3:0] FUNC_XOR   = 4'h6;
	localparam logic [3:0] FUNC_OR    = 4'h7;
	localparam logic [3:0] FUNC_NOR   = 4'h8;
	localparam logic [3:0] FUNC_XNOR  = 4'h9;
	localparam logic [3:0] FUNC_NB    = 4'ha;
	localparam logic [3:0] FUNC_AONB  = 4'hb;
	localparam logic [3:0] FUNC_NA    = 4'hc;
	localparam logic [3:0] FUNC_NAOB  = 4'hd;
	localparam logic [3:0] FUNC_NAND  = 4'he;
	localparam logic [3:0] FUNC_ONE   = 4'hf;
	localparam logic [1:0] SEL_RST    = 2'h0;

endpackage

/* rtl/cll_cell.sv */
// One two-input logic table, purely combinational.
// Assumes inputs and function word are already synchronous.
`timescale 1ns/1ps
module cll_cell
	import cll_pkg::*;
(
	input  wire logic [FUNC_W-1:0] func,
	input  wire logic              in_a,
	input  wire logic              in_b,
	output logic                   out_y
);

	// Word bit picked by inverted inputs; A=B=0 picks bit 3
	always_comb begin
		out_y = func[{~in_a, ~in_b}];
	end

endmodule // cll_cell

/* rtl/cll_bank.sv */
// Bank of four comparator logic tables with input routing.
// Holds the function words, routing selects and the table outputs.
// Assumes comparator outputs are asynchronous; fabric samples clk_sys.
// Assumes the config strobe comes from logic on clk_sys.
`timescale 1ns/1ps
module cll_bank
	import cll_pkg::*;
(
	input  wire logic                      clk_sys,
	input  wire logic                      rst,
	input  wire logic                      clk_en,
	input  wire logic [NUM_CMP-1:0]        cmp_out,
	input  wire logic                      cfg_we,
	input  wire logic [1:0]                cfg_idx,
	input  wire logic [FUNC_W-1:0]         cfg_func,
	input  wire logic [SEL_W-1:0]          cfg_sel_a,
	input  wire logic [SEL_W-1:0]          cfg_sel_b,
	output logic      [NUM_LUT-1:0]        lut_out,
	output logic      [NUM_LUT*FUNC_W-1:0] func_rd
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// True when a write strobe targets table idx
	function automatic logic cfg_hit(
		input logic       we,
		input logic [1:0] wr_idx,
		input logic [1:0] idx
	);
		return we && (wr_idx == idx);
	endfunction

	// Level of one comparator chosen by a routing select
	function automatic logic cmp_pick(
		input logic [NUM_CMP-1:0] lvl,
		input logic [SEL_W-1:0]   sel
	);
		return lvl[sel];
	endfunction

	// ----------------------------------------------------------------
	// Comparator input synchroniser
	// ----------------------------------------------------------------
	logic [NUM_CMP-1:0] cmp_s1_q;
	logic [NUM_CMP-1:0] cmp_s1_d;
	logic [NUM_CMP-1:0] cmp_s2_q;
	logic [NUM_CMP-1:0] cmp_s2_d;

	// Two stages before any logic reads comparator levels
	always_comb begin
		cmp_s1_d = cmp_out;
		cmp_s2_d = cmp_s1_q;
	end

	// Levels switch at any time; only stage two is read
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cmp_s1_q <= '0;
			cmp_s2_q <= '0;
		end else if (clk_en) begin
			cmp_s1_q <= cmp_s1_d;
			cmp_s2_q <= cmp_s2_d;
		end
	end

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	logic [NUM_LUT-1:0] wr_hit;

	// One-hot target of the write strobe
	always_comb begin
		for (int i = 0; i < NUM_LUT; i++) begin
			wr_hit[i] = cfg_hit(cfg_we, cfg_idx, 2'(i));
		end
	end

	// ----------------------------------------------------------------
	// Configuration storage: function words
	// ----------------------------------------------------------------
	logic [FUNC_W-1:0] func_q [NUM_LUT];
	logic [FUNC_W-1:0] func_d [NUM_LUT];

	// Indexed write of one table's function word
	always_comb begin
		for (int i = 0; i < NUM_LUT; i++) begin
			if (wr_hit[i]) begin
				func_d[i] = cfg_func;
			end else begin
				func_d[i] = func_q[i];
			end
		end
	end

	// Words reset to the constant-zero code
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_LUT; i++) begin
				func_q[i] <= FUNC_RST;
			end
		end else if (clk_en) begin
			for (int i = 0; i < NUM_LUT; i++) begin
				func_q[i] <= func_d[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration storage: routing selects
	// ----------------------------------------------------------------
	logic [SEL_W-1:0] sela_q [NUM_LUT];
	logic [SEL_W-1:0] sela_d [NUM_LUT];
	logic [SEL_W-1:0] selb_q [NUM_LUT];
	logic [SEL_W-1:0] selb_d [NUM_LUT];

	// Selects follow the word: same index, same edge
	always_comb begin
		for (int i = 0; i < NUM_LUT; i++) begin
			if (wr_hit[i]) begin
				sela_d[i] = cfg_sel_a;
				selb_d[i] = cfg_sel_b;
			end else begin
				sela_d[i] = sela_q[i];
				selb_d[i] = selb_q[i];
			end
		end
	end

	// Both inputs start on comparator 0
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_LUT; i++) begin
				sela_q[i] <= SEL_RST;
				selb_q[i] <= SEL_RST;
			end
		end else if (clk_en) begin
			for (int i = 0; i < NUM_LUT; i++) begin
				sela_q[i] <= sela_d[i];
				selb_q[i] <= selb_d[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// Input routing
	// ----------------------------------------------------------------
	logic [NUM_LUT-1:0] lut_a;
	logic [NUM_LUT-1:0] lut_b;

	// Any synchronised comparator to either input
	always_comb begin
		for (int i = 0; i < NUM_LUT; i++) begin
			lut_a[i] = cmp_pick(cmp_s2_q, sela_q[i]);
			lut_b[i] = cmp_pick(cmp_s2_q, selb_q[i]);
		end
	end

	// ----------------------------------------------------------------
	// Tables
	// ----------------------------------------------------------------
	logic [NUM_LUT-1:0] lut_y;

	// One table per instance; codes per the function set
	for (genvar g = 0; g < NUM_LUT; g++) begin : g_lut
		cll_cell u_cell (
			.func  (func_q[g]),
			.in_a  (lut_a[g]),
			.in_b  (lut_b[g]),
			.out_y (lut_y[g])
		);
	end

	// ----------------------------------------------------------------
	// Output registers
	// ----------------------------------------------------------------
	logic [NUM_LUT-1:0]        lut_out_d;
	logic [NUM_LUT*FUNC_W-1:0] func_rd_d;

	// Table levels toward the fabric
	always_comb begin
		lut_out_d = lut_y;
	end

	// Outputs leave from flops, one cycle after the tables
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lut_out <= '0;
		end else if (clk_en) begin
			lut_out <= lut_out_d;
		end
	end

	// Word readback, table i in nibble i
	always_comb begin
		for (int i = 0; i < NUM_LUT; i++) begin
			func_rd_d[i*FUNC_W +: FUNC_W] = func_q[i];
		end
	end

	// Readback follows the stored words by one edge
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			func_rd <= '0;
		end else if (clk_en) begin
			func_rd <= func_rd_d;
		end
	end

endmodule // cll_bank

/* bench/cll_cmp_model.sv */
// Comparator bank model feeding the tables.
// Assumes the bench sets lvl away from rising edges.
`timescale 1ns/1ps
module cll_cmp_model (
	input  wire logic       clk_sys,
	input  wire logic [3:0] lvl,
	output logic      [3:0] cmp_out
);
	// Levels settle one edge after a command
	always @(posedge clk_sys) cmp_out <= lvl;
endmodule // cll_cmp_model

/* bench/cll_bank_properties.sv */
// Output checks for the table bank.
// Assumes binding to cll_bank.
`timescale 1ns/1ps
module cll_chk (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        clk_en,
	input wire logic        cfg_we,
	input wire logic [1:0]  cfg_idx,
	input wire logic [3:0]  cfg_func,
	input wire logic [3:0]  lut_out,
	input wire logic [15:0] func_rd
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_zero_low: assert property (func_rd[3:0] == 4'h0 |-> !lut_out[0])
		else $error("table 0 not low");
	a_one_high: assert property (func_rd[7:4] == 4'hf |-> lut_out[1])
		else $error("table 1 not high");
	a_all_zero: assert property (func_rd == 16'h0 |-> lut_out == 4'h0)
		else $error("outputs not low");
	a_write_lands: assert property (cfg_we && clk_en && cfg_idx == 2'h0
		##1 clk_en [*2] |-> func_rd[3:0] == $past(cfg_func, 2))
		else $error("word not stored");
	a_word_holds: assert property (clk_en && !cfg_we ##1 clk_en
		|=> $stable(func_rd)) else $error("word changed");
	a_freeze_out: assert property (!clk_en |=> $stable(lut_out))
		else $error("output moved");
	a_rise_cause: assert property ($rose(lut_out[2])
		|-> func_rd[11:8] != 4'h0) else $error("bad rise");
	a_fall_cause: assert property ($fell(lut_out[3])
		|-> func_rd[15:12] != 4'hf) else $error("bad fall");
endmodule // cll_chk
bind cll_bank cll_chk u_chk (.clk_sys, .rst, .clk_en, .cfg_we, .cfg_idx,
	.cfg_func, .lut_out, .func_rd);

/* bench/tb.sv */
// Bench for the table bank.
// Assumes cll_cmp_model and the bound checker.
`timescale 1ns/1ps
module tb;
	logic        clk_sys = 0, rst = 1, clk_en = 1, cfg_we = 0;
	logic [1:0]  cfg_idx = 0, cfg_sel_a = 0, cfg_sel_b = 0;
	logic [3:0]  cfg_func = 0, lvl = 0, cmp_out, lut_out;
	logic [15:0] func_rd;
	int          err_total = 0, n_compared = 0;
	cll_cmp_model u_cmp (.clk_sys, .lvl, .cmp_out);
	cll_bank dut (.clk_sys, .rst, .clk_en, .cmp_out, .cfg_we, .cfg_idx,
		.cfg_func, .cfg_sel_a, .cfg_sel_b, .lut_out, .func_rd);
	initial forever #2.5 clk_sys = ~clk_sys;
	task automatic chk(string nm, logic [3:0] e, logic [3:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cfg(logic [1:0] i, logic [3:0] f, logic [1:0] sa, sb);
		@(negedge clk_sys);
		{cfg_we, cfg_idx, cfg_func, cfg_sel_a, cfg_sel_b} = {1'h1, i, f, sa, sb};
		@(negedge clk_sys);
		cfg_we = 0;
	endtask
	task automatic t_codes();
		logic [3:0] f;
		logic [1:0] ab;
		logic [3:0] e;
		for (int n = 0; n < 16; n++) begin
			f = n[3:0];
			cfg(1, f, 1, 2);
			cfg(2, f, 1, 2);
			cfg(3, f, 3, 0);
			for (int k = 0; k < 4; k++) begin
				ab = k[1:0];
				lvl = {ab, ab};
				repeat (4) @(negedge clk_sys);
				e = {{3{f[~ab]}}, 1'h0};
				chk("tables", e, lut_out);
			end
			chk("word1", f, func_rd[7:4]);
			chk("word2", f, func_rd[11:8]);
			chk("word3", f, func_rd[15:12]);
		end
	endtask
	task automatic t_freeze();
		clk_en = 0;
		cfg(0, 4'hf, 0, 0);
		repeat (3) @(negedge clk_sys);
		chk("frozen", 4'h0, func_rd[3:0]);
		chk("held", 4'he, lut_out);
		clk_en = 1;
		cfg(0, 4'hf, 0, 0);
		repeat (2) @(negedge clk_sys);
		chk("outs", 4'hf, lut_out);
	endtask
	task automatic give_verdict();
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge clk_sys);
		rst = 0;
		chk("reset", 4'h0, lut_out | func_rd[3:0]);
		t_codes();
		t_freeze();
		give_verdict();
	end
	initial begin
		#20000;
		err_total++;
		give_verdict();
	end
endmodule // tb
